// ### rtl/dhg_regs.vh
/*
  register offsets, field positions, reset values and filter
  coefficients of the final half-band, gain and complex-to-real block.
  assumes it is included by bare name from the rtl files.
*/
`ifndef DHG_REGS_VH
`define DHG_REGS_VH

// register offsets, 12-bit byte address space
`define DHG_PAIR_OFS     12'h009
`define DHG_CTRL_OFS     12'h310
`define DHG_STAT_OFS     12'h312

// control register fields
`define DHG_DECIM_LSB    0
`define DHG_DECIM_MSB    1
`define DHG_C2R_BIT      3
`define DHG_GAIN_BIT     6
`define DHG_DECIM_BY2    2'h3
`define DHG_CTRL_RST     8'h00
`define DHG_PAIR_RST     8'h00

// status register fields
`define DHG_ST_SAT_BIT   0
`define DHG_ST_PEND_BIT  1
`define DHG_ST_HB3_BIT   2
`define DHG_ST_C2R_BIT   3

// third stage: 18-bit odd pairs, outermost in the high slot
`define DHG_HB3_CW       18
`define DHG_HB3_NP       5
`define DHG_HB3_COEFS    {18'h00058, 18'h3FD46, 18'h00BA5, 18'h3DA05, 18'h09CB8}

// final stage: 20-bit odd pairs, outermost in the high slot
`define DHG_HB4_CW       20
`define DHG_HB4_NP       16
`define DHG_HB4_COEFS    {20'hFFFF6, 20'h00026, 20'hFFF9A, 20'h000E8, \
                          20'hFFE2D, 20'h0035E, 20'hFFA2F, 20'h00988, \
                          20'hFF107, 20'h016C7, 20'hFDE19, 20'h03203, \
                          20'hFB572, 20'h07476, 20'hF2F53, 20'h288FA}

`endif

// ### rtl/dhg_fifo.v
/*
  small synchronous fifo with a registered read stage.
  assumes one clock, asynchronous active-low reset.
*/
`timescale 1ns/1ps
module dhg_fifo #(
  parameter WIDTH = 32,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             clk,       // sample clock
  input  wire             nrst,      // async reset, low
  input  wire             wr_valid,  // writer offers a word
  input  wire [WIDTH-1:0] wr_data,   // word offered
  output reg              wr_ready,  // room for a word
  output reg              rd_valid,  // read stage holds a word
  output reg  [WIDTH-1:0] rd_data,   // word held
  input  wire             rd_ready   // reader takes the word
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wptr_q;
  reg [AW-1:0]    rptr_q;
  reg [AW:0]      cnt_q;
  wire            push = wr_valid & wr_ready;
  wire            load = (cnt_q != {(AW+1){1'b0}}) & (~rd_valid | rd_ready);
  wire [AW:0]     cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};

  // storage carries no reset; pointers, count, ready and read stage do
  always @(posedge clk) begin
    if (push) begin
      mem[wptr_q] <= wr_data;
    end
  end

  // pointers, fill count and registered ready
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wptr_q   <= {AW{1'b0}};
      rptr_q   <= {AW{1'b0}};
      cnt_q    <= {(AW+1){1'b0}};
      wr_ready <= 1'b0;
      rd_valid <= 1'b0;
      rd_data  <= {WIDTH{1'b0}};
    end else begin
      cnt_q    <= cnt_d;
      wr_ready <= (cnt_d < DEPTH);
      if (push) wptr_q <= wptr_q + 1'b1;
      if (load) begin
        rptr_q  <= rptr_q + 1'b1;
        rd_data <= mem[rptr_q];
      end
      if (load) rd_valid <= 1'b1;
      else if (rd_ready) rd_valid <= 1'b0;
    end
  end
endmodule

// ### rtl/dhg_halfband.v
/*
  decimate-by-2 half-band fir for an i/q pair, one output register.
  assumes COEFS packs the odd pairs, innermost in the low slot.
*/
`timescale 1ns/1ps
module dhg_halfband #(
  parameter DATA_W = 16,
  parameter COEF_W = 18,
  parameter NPAIR  = 5,
  parameter [NPAIR*COEF_W-1:0] COEFS = {NPAIR*COEF_W{1'b0}}
) (
  input  wire              clk,       // sample clock
  input  wire              nrst,      // async reset, low
  input  wire              bypass,    // pass input straight through
  input  wire              decim,     // keep every second output
  input  wire              in_valid,  // input sample strobe
  input  wire [DATA_W-1:0] in_i,      // in-phase input
  input  wire [DATA_W-1:0] in_q,      // quadrature input
  output reg               out_valid, // output sample strobe
  output reg  [DATA_W-1:0] out_i,     // in-phase output
  output reg  [DATA_W-1:0] out_q,     // quadrature output
  output reg               out_sat    // output was clipped
);
  localparam NTAP  = 4*NPAIR-1;
  localparam CTR   = 2*NPAIR-1;
  localparam ACC_W = DATA_W+COEF_W+8;
  reg  [2*DATA_W-1:0]      line_q [0:NTAP-2];
  wire [2*DATA_W-1:0]      tap_w [0:NTAP-1];
  wire signed [ACC_W-1:0]  prod [0:2*NPAIR-1];
  reg  signed [ACC_W-1:0]  acc [0:1];
  reg  signed [ACC_W-1:0]  shr [0:1];
  reg                      phase_q;
  reg  [1:0]               sat_l;
  reg  [DATA_W-1:0]        res [0:1];
  integer                  n;
  integer                  j;
  integer                  r;
  genvar                   k, l;

  // tap 0 is the sample arriving now, so output follows in one cycle
  assign tap_w[0] = {in_q, in_i};
  generate
    for (k = 1; k < NTAP; k = k + 1) begin : g_tap
      assign tap_w[k] = line_q[k-1];
    end
    // even pairs are zero: only odd offsets from the centre multiply
    for (l = 0; l < 2; l = l + 1) begin : g_lane
      for (k = 0; k < NPAIR; k = k + 1) begin : g_pair
        wire signed [DATA_W-1:0] a = tap_w[CTR-2*k-1][l*DATA_W +: DATA_W];
        wire signed [DATA_W-1:0] b = tap_w[CTR+2*k+1][l*DATA_W +: DATA_W];
        wire signed [DATA_W:0]   s = {a[DATA_W-1], a} + {b[DATA_W-1], b};
        wire signed [COEF_W-1:0] c = COEFS[k*COEF_W +: COEF_W];
        assign prod[l*NPAIR+k] = s * c;
      end
    end
  endgenerate

  // centre tap is a half: a shift instead of a multiplier
  always @* begin
    for (n = 0; n < 2; n = n + 1) begin
      acc[n] = $signed(tap_w[CTR][n*DATA_W +: DATA_W]) <<< (COEF_W-2);
      for (j = 0; j < NPAIR; j = j + 1) acc[n] = acc[n] + prod[n*NPAIR+j];
      shr[n] = (acc[n] + (1 <<< (COEF_W-2))) >>> (COEF_W-1);
      sat_l[n] = 1'b0;
      res[n] = shr[n][DATA_W-1:0];
      if (shr[n] > $signed({1'b0, {(DATA_W-1){1'b1}}})) begin
        res[n] = {1'b0, {(DATA_W-1){1'b1}}};
        sat_l[n] = 1'b1;
      end else if (shr[n] < -$signed({1'b0, {(DATA_W-1){1'b1}}}) - 1) begin
        res[n] = {1'b1, {(DATA_W-1){1'b0}}};
        sat_l[n] = 1'b1;
      end
    end
  end

  // delay line, decimation phase and output register
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (r = 0; r < NTAP-1; r = r + 1) line_q[r] <= {2*DATA_W{1'b0}};
      phase_q   <= 1'b0;
      out_valid <= 1'b0;
      out_i     <= {DATA_W{1'b0}};
      out_q     <= {DATA_W{1'b0}};
      out_sat   <= 1'b0;
    end else begin
      out_valid <= 1'b0;
      out_sat   <= 1'b0;
      if (in_valid) begin
        for (r = 1; r < NTAP-1; r = r + 1) line_q[r] <= line_q[r-1];
        line_q[0] <= {in_q, in_i};
        phase_q   <= decim ? ~phase_q : 1'b0;
        out_valid <= bypass | ~decim | phase_q;
        out_i     <= bypass ? in_i : res[0];
        out_q     <= bypass ? in_q : res[1];
        out_sat   <= ~bypass & (sat_l[0] | sat_l[1]);
      end
    end
  end
endmodule

// ### rtl/dhg_top.v
/*
  final part of one downconverter channel: fifo, bypassable third
  half-band stage, always-on final half-band stage, 0/6 dB gain and
  optional complex-to-real conversion, plus a small register port.
  assumes samples arrive on the sample clock from the mixer stages
  and the framer takes output with a valid/ready handshake.
*/
// Our own choices: the register addresses and the strobed register port.
// Summary of operation
// - third stage: 19-tap half-band, decimate by 2
// - third stage runs only for decimation 4/8/16
// - third stage coefficients 88 .. 40120, centre 65536
// - final stage: 63-tap half-band, decimate by 2
// - final stage always enabled, never bypassed
// - final stage coefficients -10 .. 166138, centre 262144
// - third stage feeds the final stage
// - per-channel gain of 0 dB or 6 dB
// - complex-to-real stops final stage decimation
// - complex-to-real reuses final filter, fs/4 mixer
// - quadrature mixer output dropped, in-phase kept
// - decimation in control bits 1:0, pair selected
`timescale 1ns/1ps
`include "dhg_regs.vh"
module dhg_top #(
  parameter        DATA_W    = 16,
  parameter        FIFO_D    = 8,
  parameter        FIFO_AW   = 3,
  parameter [11:0] CTRL_ADDR = `DHG_CTRL_OFS,
  parameter [11:0] STAT_ADDR = `DHG_STAT_OFS,
  parameter        PAIR_BIT  = 0
) (
  input  wire              clk,       // sample clock, 25 MHz
  input  wire              nrst,      // async reset, low
  input  wire [11:0]       reg_addr,  // register address
  input  wire [7:0]        reg_wdata, // register write data
  input  wire              reg_wr,    // write strobe
  input  wire              reg_rd,    // read strobe
  output reg  [7:0]        reg_rdata, // read data, cycle after strobe
  input  wire              in_valid,  // input sample offered
  input  wire [DATA_W-1:0] in_i,      // input in-phase
  input  wire [DATA_W-1:0] in_q,      // input quadrature
  output wire              in_ready,  // fifo has room
  output reg               out_valid, // output sample held
  output reg  [DATA_W-1:0] out_i,     // output in-phase or real
  output reg  [DATA_W-1:0] out_q,     // output quadrature, 0 if real
  input  wire              out_ready  // framer takes sample
);
  // register state
  reg  [7:0]          pair_q;
  reg  [7:0]          ctrl_q;
  reg                 sat_q;
  reg  [1:0]          nco_q;
  reg  [1:0]          pend_q;

  // fifo drain side
  wire                f_valid;
  wire [2*DATA_W-1:0] f_data;
  wire                idle;
  wire                pop;

  // third stage results
  wire                t_valid;
  wire [DATA_W-1:0]   t_i;
  wire [DATA_W-1:0]   t_q;
  wire                t_sat;

  // final stage results
  wire                h_valid;
  wire [DATA_W-1:0]   h_i;
  wire [DATA_W-1:0]   h_q;
  wire                h_sat;

  // decoded control
  wire [1:0]          decim_sel;
  wire                hb3_on;
  wire                c2r_on;
  wire                gain_on;
  wire                sel;
  wire                wr_ctrl;
  wire                wr_stat;

  // post-filter arithmetic
  reg  [DATA_W-1:0]   g_i;
  reg  [DATA_W-1:0]   g_q;
  reg                 g_sat;
  reg                 gq_s;
  reg  [DATA_W-1:0]   m_i;
  reg                 m_sat;
  reg                 clip_flag;

  localparam [DATA_W-1:0] MAXV = {1'b0, {(DATA_W-1){1'b1}}};
  localparam [DATA_W-1:0] MINV = {1'b1, {(DATA_W-1){1'b0}}};

  // doubling with clip, so 6 dB never wraps a full-scale sample
  function [DATA_W:0] dbl;
    input [DATA_W-1:0] v;
    begin
      if (v[DATA_W-1] != v[DATA_W-2]) begin
        dbl = {1'b1, v[DATA_W-1] ? MINV : MAXV};
      end else begin
        dbl = {1'b0, v[DATA_W-2:0], 1'b0};
      end
    end
  endfunction

  // negation with clip: the most negative code has no positive twin
  function [DATA_W:0] neg;
    input [DATA_W-1:0] v;
    begin
      if (v == MINV) begin
        neg = {1'b1, MAXV};
      end else begin
        neg = {1'b0, (~v) + {{(DATA_W-1){1'b0}}, 1'b1}};
      end
    end
  endfunction

  // control decode
  assign decim_sel = ctrl_q[`DHG_DECIM_MSB:`DHG_DECIM_LSB];
  assign hb3_on    = (decim_sel != `DHG_DECIM_BY2);
  assign c2r_on    = ctrl_q[`DHG_C2R_BIT];
  assign gain_on   = ctrl_q[`DHG_GAIN_BIT];
  assign sel       = pair_q[PAIR_BIT];
  assign wr_ctrl   = reg_wr & sel & (reg_addr == CTRL_ADDR);
  assign wr_stat   = reg_wr & sel & (reg_addr == STAT_ADDR);

  // one sample in flight at a time keeps the filters free of stalls;
  // throughput is one sample per three clocks, four when it yields an output; the fifo absorbs bursts
  assign idle = (pend_q == 2'b00) & ~out_valid;
  assign pop  = f_valid & idle;

  dhg_fifo #(
    .WIDTH (2*DATA_W),
    .DEPTH (FIFO_D),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk      (clk),
    .nrst     (nrst),
    .wr_valid (in_valid),
    .wr_data  ({in_q, in_i}),
    .wr_ready (in_ready),
    .rd_valid (f_valid),
    .rd_data  (f_data),
    .rd_ready (idle)
  );

  // third stage, bypassed when the channel decimates by 2 only
  dhg_halfband #(
    .DATA_W (DATA_W),
    .COEF_W (`DHG_HB3_CW),
    .NPAIR  (`DHG_HB3_NP),
    .COEFS  (`DHG_HB3_COEFS)
  ) u_halfband_third_stage (
    .clk       (clk),
    .nrst      (nrst),
    .bypass    (~hb3_on),
    .decim     (1'b1),
    .in_valid  (pop),
    .in_i      (f_data[DATA_W-1:0]),
    .in_q      (f_data[2*DATA_W-1:DATA_W]),
    .out_valid (t_valid),
    .out_i     (t_i),
    .out_q     (t_q),
    .out_sat   (t_sat)
  );

  // final stage takes the third stage output and is never bypassed
  dhg_halfband #(
    .DATA_W (DATA_W),
    .COEF_W (`DHG_HB4_CW),
    .NPAIR  (`DHG_HB4_NP),
    .COEFS  (`DHG_HB4_COEFS)
  ) u_halfband_final_stage (
    .clk       (clk),
    .nrst      (nrst),
    .bypass    (1'b0),
    .decim     (~c2r_on),
    .in_valid  (t_valid),
    .in_i      (t_i),
    .in_q      (t_q),
    .out_valid (h_valid),
    .out_i     (h_i),
    .out_q     (h_q),
    .out_sat   (h_sat)
  );

  // gain stage, then the fs/4 upconversion of the filtered pair
  always @* begin
    g_i   = h_i;
    g_q   = h_q;
    g_sat = 1'b0;
    gq_s  = 1'b0;
    if (gain_on) begin
      {g_sat, g_i} = dbl(h_i);
      {gq_s, g_q}  = dbl(h_q);
      g_sat = g_sat | gq_s;
    end
    // real part of (i + jq) times e^(j pi n / 2)
    m_i   = g_i;
    m_sat = 1'b0;
    case (nco_q)
      2'h0: begin
        m_i = g_i;
      end
      2'h1: begin
        {m_sat, m_i} = neg(g_q);
      end
      2'h2: begin
        {m_sat, m_i} = neg(g_i);
      end
      2'h3: begin
        m_i = g_q;
      end
      default: begin
        m_i = g_i;
      end
    endcase
    clip_flag = t_sat | (h_valid & (h_sat | g_sat | (c2r_on & m_sat)));
  end

  // in-flight tracking: pop, then third stage, then final stage
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pend_q <= 2'b00;
    end else begin
      pend_q <= {pend_q[0], pop};
    end
  end

  // mixer phase advances per final stage output in real mode only
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      nco_q <= 2'h0;
    end else if (!c2r_on) begin
      nco_q <= 2'h0;
    end else if (h_valid) begin
      nco_q <= nco_q + 2'h1;
    end
  end

  // output register, held until the framer takes it
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_valid <= 1'b0;
      out_i     <= {DATA_W{1'b0}};
      out_q     <= {DATA_W{1'b0}};
    end else begin
      if (h_valid) begin
        out_valid <= 1'b1;
        out_i     <= c2r_on ? m_i : g_i;
        out_q     <= c2r_on ? {DATA_W{1'b0}} : g_q;
      end else if (out_ready) begin
        out_valid <= 1'b0;
      end
    end
  end

  // control and pair index; mode changes apply from the next clock, even to a sample already in flight
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pair_q <= `DHG_PAIR_RST;
      ctrl_q <= `DHG_CTRL_RST;
    end else begin
      if (reg_wr && reg_addr == `DHG_PAIR_OFS) begin
        pair_q <= reg_wdata;
      end
      if (wr_ctrl) begin
        ctrl_q <= reg_wdata;
      end
    end
  end

  // sticky clip flag, write one to clear; a new clip wins the tie
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sat_q <= 1'b0;
    end else if (clip_flag) begin
      sat_q <= 1'b1;
    end else if (wr_stat && reg_wdata[`DHG_ST_SAT_BIT]) begin
      sat_q <= 1'b0;
    end
  end

  // read data stand only in the cycle after the strobe
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        case (reg_addr)
          `DHG_PAIR_OFS: begin
            reg_rdata <= pair_q;
          end
          CTRL_ADDR: begin
            reg_rdata <= sel ? ctrl_q : 8'h00;
          end
          STAT_ADDR: begin
            reg_rdata <= sel ? {4'h0, c2r_on, hb3_on, f_valid, sat_q} : 8'h00;
          end
          default: begin
            reg_rdata <= 8'h00;
          end
        endcase
      end
    end
  end
endmodule

// ### bench/dhg_top_monitor.sv
/*
  checker for the dhg_top ports: register replies, output hold and
  the visible effect of gain and complex-to-real modes.
  assumes a bind onto dhg_top, one clock, nrst low asynchronous.
*/
`timescale 1ns/1ps
`include "dhg_regs.vh"
module dhg_top_monitor #(
  parameter        DATA_W    = 16,
  parameter [11:0] CTRL_ADDR = `DHG_CTRL_OFS,
  parameter [11:0] STAT_ADDR = `DHG_STAT_OFS,
  parameter        PAIR_BIT  = 0
) (
  input wire              clk,       // sample clock
  input wire              nrst,      // async reset, low
  input wire [11:0]       reg_addr,  // register address
  input wire [7:0]        reg_wdata, // write data
  input wire              reg_wr,    // write strobe
  input wire              reg_rd,    // read strobe
  input wire [7:0]        reg_rdata, // read data
  input wire              in_valid,  // sample offered
  input wire [DATA_W-1:0] in_i,      // input i
  input wire [DATA_W-1:0] in_q,      // input q
  input wire              in_ready,  // fifo room
  input wire              out_valid, // output held
  input wire [DATA_W-1:0] out_i,     // output i
  input wire [DATA_W-1:0] out_q,     // output q
  input wire              out_ready  // framer takes
);
  localparam [DATA_W-1:0] MAXP = {1'b0, {(DATA_W-1){1'b1}}};
  localparam [DATA_W-1:0] NMAX = ~MAXP + 1'b1;
  logic [7:0] pair_q; // pair index shadow
  logic [7:0] ctrl_q; // control shadow
  logic [1:0] outs_q; // outputs taken since mode change
  wire        sel = pair_q[PAIR_BIT];
  // outs_q saturates; samples of the old mode still in flight pass unchecked
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pair_q <= `DHG_PAIR_RST;
      ctrl_q <= `DHG_CTRL_RST;
      outs_q <= 2'h0;
    end else begin
      if (reg_wr && reg_addr == `DHG_PAIR_OFS) pair_q <= reg_wdata;
      if (reg_wr && reg_addr == CTRL_ADDR && sel) begin
        ctrl_q <= reg_wdata;
        outs_q <= 2'h0;
      end else if (out_valid && out_ready && outs_q != 2'h3) begin
        outs_q <= outs_q + 2'h1;
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_ctrl_rd;
    reg_rd && (reg_addr == CTRL_ADDR || reg_addr == STAT_ADDR);
  endsequence
  sequence s_offer;
    out_valid && !out_ready;
  endsequence
  sequence s_taken;
    out_valid && out_ready;
  endsequence
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside a reply");
  a_pair_gate: assert property ((s_ctrl_rd ##0 !sel) |=> reg_rdata == 8'h00)
    else $error("unselected channel answered a read");
  a_ctrl_readback: assert property ((reg_rd && reg_addr == CTRL_ADDR && sel)
    |=> reg_rdata == $past(ctrl_q)) else $error("control read back differs");
  a_stat_mode: assert property ((reg_rd && reg_addr == STAT_ADDR && sel)
    |=> reg_rdata[3:2] == {$past(ctrl_q[`DHG_C2R_BIT]), $past(ctrl_q[1:0]) != `DHG_DECIM_BY2})
    else $error("status mode bits differ from control");
  a_unmapped_zero: assert property ((reg_rd && reg_addr != `DHG_PAIR_OFS
    && reg_addr != CTRL_ADDR && reg_addr != STAT_ADDR) |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_out_hold: assert property (s_offer |=> out_valid && $stable(out_i) && $stable(out_q))
    else $error("output changed while stalled");
  a_out_drop: assert property (s_taken |=> !out_valid [*2])
    else $error("output rate above one per three clocks");
  a_c2r_qzero: assert property ((out_valid && ctrl_q[`DHG_C2R_BIT] && outs_q == 2'h3)
    |-> out_q == '0) else $error("quadrature output not dropped");
  a_gain_even: assert property ((out_valid && ctrl_q[`DHG_GAIN_BIT] && outs_q == 2'h3
    && out_i != MAXP && out_i != NMAX) |-> !out_i[0]) else $error("gain output odd");
endmodule

// ### bench/dhg_stream_partner.sv
/*
  far side model: mixer source with handshake and framer sink.
  assumes the testbench sets the sample pair, a send limit and a sink mode.
*/
`timescale 1ns/1ps
module dhg_stream_partner (
  input  wire         clk,       // sample clock
  input  wire         nrst,      // async reset, low
  input  wire         in_ready,  // fifo room
  output logic        in_valid,  // sample offered
  output logic [15:0] in_i,      // offered i
  output logic [15:0] in_q,      // offered q
  input  wire         out_valid, // output held
  input  wire  [15:0] out_i,     // output i
  input  wire  [15:0] out_q,     // output q
  output logic        out_ready, // sink takes
  input  wire  [15:0] src_i,     // value to send
  input  wire  [15:0] src_q,     // value to send
  input  wire  [15:0] src_lim,   // send until tx_cnt reaches it
  input  wire  [1:0]  snk_mode   // 0 ready, 1 stall, 2 every other
);
  logic [15:0] tx_cnt;   // samples taken by the fifo
  logic [15:0] rx_cnt;   // outputs taken
  logic [15:0] rx_i [4]; // last four outputs
  logic [15:0] rx_q [4];
  logic        tog;
  wire  [15:0] tx_nxt = tx_cnt + {15'h0000, in_valid && in_ready};
  wire         more   = tx_nxt < src_lim;
  // an offer and its data stay put until taken; idle lines show the inverse
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      in_valid <= 1'b0;
      in_i     <= 16'h0000;
      in_q     <= 16'h0000;
      tx_cnt   <= 16'h0000;
    end else begin
      tx_cnt <= tx_nxt;
      if (!in_valid || in_ready) begin
        in_valid <= more;
        in_i     <= more ? src_i : ~src_i;
        in_q     <= more ? src_q : ~src_q;
      end
    end
  end
  // sink may stall to exercise output hold
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_ready <= 1'b0;
      rx_cnt    <= 16'h0000;
      tog       <= 1'b0;
    end else begin
      tog       <= ~tog;
      out_ready <= (snk_mode == 2'h0) || (snk_mode == 2'h2 && tog);
      if (out_valid && out_ready) begin
        rx_i[rx_cnt[1:0]] <= out_i;
        rx_q[rx_cnt[1:0]] <= out_q;
        rx_cnt            <= rx_cnt + 16'h0001;
      end
    end
  end
endmodule

// ### bench/dhg_top_tb_top.sv
/*
  testbench for dhg_top: register sequences, decimation counts, dc levels,
  gain, clipping, complex-to-real and fifo stall.
  assumes the partner model and the monitor are compiled before it.
*/
`timescale 1ns/1ps
`include "dhg_regs.vh"
module dhg_top_tb_top;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0]  reg_wdata = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  wire  [7:0]  reg_rdata;
  wire         in_valid, in_ready, out_valid, out_ready;
  wire  [15:0] in_i, in_q, out_i, out_q;
  logic [15:0] src_i = 16'h0000, src_q = 16'h0000, src_lim = 16'h0000;
  logic [1:0]  snk_mode = 2'h0;
  logic [15:0] base;
  logic signed [15:0] s;
  int          err_count = 0, checked = 0, cyc = 0, k;
  always #20 clk = ~clk;
  dhg_top dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .in_valid(in_valid),
    .in_i(in_i), .in_q(in_q), .in_ready(in_ready), .out_valid(out_valid),
    .out_i(out_i), .out_q(out_q), .out_ready(out_ready));
  dhg_stream_partner u_far (.clk(clk), .nrst(nrst), .in_ready(in_ready),
    .in_valid(in_valid), .in_i(in_i), .in_q(in_q), .out_valid(out_valid),
    .out_i(out_i), .out_q(out_q), .out_ready(out_ready), .src_i(src_i),
    .src_q(src_q), .src_lim(src_lim), .snk_mode(snk_mode));
  task automatic conclude;
    $display("checks %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      $display("wrong value %s: expected %h, seen %h", nm, e, g);
      err_count++;
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rdc(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk("register", {8'h00, e}, {8'h00, reg_rdata & m});
  endtask
  task automatic do_reset;
    @(posedge clk);
    nrst    <= 1'b0;
    src_lim <= 16'h0000;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
  endtask
  // send m samples, let the pipe drain, then compare the output count
  task automatic burst(input logic [15:0] m, input logic [15:0] n);
    logic [15:0] r0;
    int t;
    r0 = u_far.rx_cnt;
    @(posedge clk);
    src_lim <= u_far.tx_cnt + m;
    #1;
    t = 0;
    while (u_far.tx_cnt != src_lim && t < 5000) begin
      @(posedge clk);
      t++;
    end
    if (t >= 5000) err_count++;
    repeat (100) @(posedge clk);
    chk("output count", n, u_far.rx_cnt - r0);
  endtask
  task automatic last(input logic [15:0] ei, input logic [15:0] eq);
    chk("last i", ei, u_far.rx_i[u_far.rx_cnt[1:0] - 2'h1]);
    chk("last q", eq, u_far.rx_q[u_far.rx_cnt[1:0] - 2'h1]);
  endtask
  // hang guard, well above the expected run of about 9000 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      conclude;
    end
  end
  initial begin
    do_reset;
    rdc(`DHG_CTRL_OFS, 8'hFF, 8'h00);
    wr(`DHG_CTRL_OFS, 8'h48);
    wr(`DHG_PAIR_OFS, 8'h01);
    rdc(`DHG_CTRL_OFS, 8'hFF, 8'h00);
    wr(`DHG_CTRL_OFS, 8'h83);
    rdc(`DHG_CTRL_OFS, 8'hFF, 8'h83);
    rdc(12'h311, 8'hFF, 8'h00);
    src_i <= 16'h03E8;
    src_q <= 16'hFE0C;
    // modes 3,0,1,2: third stage only for 4/8/16, final stage always halves
    for (k = 0; k < 4; k++) begin
      wr(`DHG_CTRL_OFS, 8'((k + 3) % 4));
      rdc(`DHG_STAT_OFS, 8'h0C, (k == 0) ? 8'h00 : 8'h04);
      burst(16'd256, (k == 0) ? 16'd128 : 16'd64);
      last(16'h03E8, 16'hFE0C);
    end
    wr(`DHG_CTRL_OFS, 8'h43);
    snk_mode <= 2'h2;
    burst(16'd256, 16'd128);
    last(16'h07D0, 16'hFC18);
    src_i <= 16'h4E20;
    src_q <= 16'hB1E0;
    burst(16'd256, 16'd128);
    last(16'h7FFF, 16'h8000);
    rdc(`DHG_STAT_OFS, 8'h01, 8'h01);
    wr(`DHG_STAT_OFS, 8'h01);
    rdc(`DHG_STAT_OFS, 8'h01, 8'h00);
    snk_mode <= 2'h0;
    src_i <= 16'h03E8;
    src_q <= 16'h0000;
    wr(`DHG_CTRL_OFS, 8'h0B);
    burst(16'd256, 16'd256);
    // real stream of a dc tone is +d, 0, -d, 0 in some phase
    for (k = 0; k < 4; k++) begin
      chk("c2r q", 16'h0000, u_far.rx_q[k]);
      s = u_far.rx_i[k] + u_far.rx_i[(k + 1) % 4];
      chk("c2r pair", 16'h03E8, s[15] ? -s : s);
      chk("c2r half", 16'h0000, u_far.rx_i[k] + u_far.rx_i[(k + 2) % 4]);
    end
    wr(`DHG_CTRL_OFS, 8'h08);
    rdc(`DHG_STAT_OFS, 8'h0C, 8'h0C);
    burst(16'd256, 16'd128);
    snk_mode <= 2'h1;
    base = u_far.tx_cnt;
    @(posedge clk);
    src_lim <= base + 16'd40;
    repeat (100) @(posedge clk);
    chk("in_ready full", 16'h0000, {15'h0000, in_ready});
    chk("fifo taken", 16'h0001, {15'h0000, (u_far.tx_cnt - base) >= 16'd8});
    rdc(`DHG_STAT_OFS, 8'h02, 8'h02);
    snk_mode <= 2'h0;
    repeat (400) @(posedge clk);
    chk("in_ready drained", 16'h0001, {15'h0000, in_ready});
    do_reset;
    wr(`DHG_PAIR_OFS, 8'h01);
    rdc(`DHG_CTRL_OFS, 8'hFF, 8'h00);
    conclude;
  end
endmodule
bind dhg_top dhg_top_monitor #(.DATA_W(DATA_W), .CTRL_ADDR(CTRL_ADDR),
  .STAT_ADDR(STAT_ADDR), .PAIR_BIT(PAIR_BIT)) u_mon (.clk(clk), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .in_valid(in_valid), .in_i(in_i), .in_q(in_q),
  .in_ready(in_ready), .out_valid(out_valid), .out_i(out_i), .out_q(out_q),
  .out_ready(out_ready));
